// ### hdl/dual_clock_fifo_status_sync.sv
// fifo with gray pointer crossings, pessimistic flags and per-side word counts
//
// Functional notes
// RULE1: full clears no sooner than one read period plus 3+N write periods; the code clears it 3+N periods after the pop edge.
// RULE2: empty clears no sooner than one write period plus 3+N read periods.
// RULE3: integrator keeps full-clear delay shorter than draining a full fifo.
// RULE4: integrator keeps empty-clear delay shorter than filling an empty fifo.
// RULE5: one word count on the write side, another on the read side.
// RULE6: word counts may lag and jump; approximate while traffic flows.
// RULE7: after a few idle cycles both counts equal the stored word count.
// RULE8: crossing tolerates any phase or rate relation of the two sides.
// RULE9: optional wide read port and first-word fall-through read mode.
// RULE10: full sets on the edge where the fifo becomes full.
// RULE11: empty sets on the edge where the fifo becomes empty.
// RULE12: pointers cross in gray code through the N-stage chain.
`timescale 1ns/1ns
`default_nettype none
module dual_clock_fifo_status_sync
(
   input  wire logic                              core_clk_i,
   input  wire logic                              rst_b_i,
   input  wire logic                              wr_valid_i,
   input  wire logic [fifo_sync_pkg::DATA_W-1:0]  wr_data_i,
   output logic                                   wr_ready_o,
   output logic                                   full_o,
   output logic [fifo_sync_pkg::PTR_W-1:0]        wr_count_o,
   input  wire logic                              rd_en_i,
   input  wire logic                              fwft_mode_i,
   input  wire logic                              wide_read_i,
   output logic [fifo_sync_pkg::RD_W-1:0]         rd_data_o,
   output logic                                   rd_valid_o,
   output logic                                   empty_o,
   output logic [fifo_sync_pkg::PTR_W-1:0]        rd_count_o
);
   logic [fifo_sync_pkg::DATA_W-1:0] mem_reg [fifo_sync_pkg::DEPTH];
   logic [fifo_sync_pkg::DATA_W-1:0] buf_data;
   logic [fifo_sync_pkg::DATA_W-1:0] head;
   logic                             buf_valid;
   logic                             push;
   logic                             pop;
   fifo_sync_pkg::ptr_t              wr_ptr_reg;
   fifo_sync_pkg::ptr_t              wr_ptr_next;
   fifo_sync_pkg::ptr_t              rd_ptr_reg;
   fifo_sync_pkg::ptr_t              rd_ptr_next;
   fifo_sync_pkg::ptr_t              wr_gray_reg;
   fifo_sync_pkg::ptr_t              rd_gray_reg;
   fifo_sync_pkg::ptr_t              wr_sync_reg [fifo_sync_pkg::SYNC_STAGES];
   fifo_sync_pkg::ptr_t              rd_sync_reg [fifo_sync_pkg::SYNC_STAGES];
   fifo_sync_pkg::ptr_t              wr_bin_pipe_reg;
   fifo_sync_pkg::ptr_t              rd_bin_pipe_reg;
   fifo_sync_pkg::ptr_t              wr_count_reg;
   fifo_sync_pkg::ptr_t              rd_count_reg;
   logic                             full_reg;
   logic                             core_empty_reg;
   fifo_sync_pkg::read_state_t       state_reg;
   fifo_sync_pkg::read_state_t       state_next;
   logic [fifo_sync_pkg::RD_W-1:0]   rd_data_reg;
   logic                             valid_reg;
   logic                             valid_next;
   function automatic fifo_sync_pkg::ptr_t bin2gray(input fifo_sync_pkg::ptr_t b);
      return b ^ (b >> 1);
   endfunction
   function automatic fifo_sync_pkg::ptr_t gray2bin(input fifo_sync_pkg::ptr_t g);
      fifo_sync_pkg::ptr_t b;
      b = g;
      for (int i = fifo_sync_pkg::PTR_W - 2; i >= 0; i--)
         b[i] = b[i+1] ^ g[i];
      return b;
   endfunction
   // staging buffer absorbs bursts; it drains only while full is clear
   stream_fifo
   #(
      .WIDTH (fifo_sync_pkg::DATA_W),
      .DEPTH (fifo_sync_pkg::BUF_DEPTH)
   )
   u_stage
   (
      .core_clk_i  (core_clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (wr_valid_i),
      .in_ready_o  (wr_ready_o),
      .in_data_i   (wr_data_i),
      .out_valid_o (buf_valid),
      .out_ready_i (!full_reg),
      .out_data_o  (buf_data)
   );
   // write side: pessimistic full compares against a delayed read pointer
   assign push        = buf_valid && !full_reg;
   assign wr_ptr_next = wr_ptr_reg + fifo_sync_pkg::ptr_t'(push);
   assign head        = mem_reg[rd_ptr_reg[fifo_sync_pkg::ADDR_W-1:0]];
   always_ff @(posedge core_clk_i)
   begin
      if (push)
         mem_reg[wr_ptr_reg[fifo_sync_pkg::ADDR_W-1:0]] <= buf_data;
   end
   // full sets at once from the write pointer, clears only once the read news lands
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         wr_ptr_reg   <= fifo_sync_pkg::PTR_RST;
         full_reg     <= fifo_sync_pkg::FULL_RST;
         wr_count_reg <= fifo_sync_pkg::PTR_RST;
      end
      else
      begin
         wr_ptr_reg   <= wr_ptr_next;
         full_reg     <= (wr_ptr_next - rd_bin_pipe_reg) == fifo_sync_pkg::FULL_LEVEL; // RULE10 RULE1
         wr_count_reg <= wr_ptr_next - rd_bin_pipe_reg; // RULE5 RULE6
      end
   end
   // gray registers, n-stage chains and a decode stage in each direction;
   // first chain stage feeds only the second, so metastable samples stay contained
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         wr_gray_reg     <= fifo_sync_pkg::PTR_RST;
         rd_gray_reg     <= fifo_sync_pkg::PTR_RST;
         wr_bin_pipe_reg <= fifo_sync_pkg::PTR_RST;
         rd_bin_pipe_reg <= fifo_sync_pkg::PTR_RST;
         for (int i = 0; i < fifo_sync_pkg::SYNC_STAGES; i++)
         begin
            wr_sync_reg[i] <= fifo_sync_pkg::PTR_RST;
            rd_sync_reg[i] <= fifo_sync_pkg::PTR_RST;
         end
      end
      else
      begin
         wr_gray_reg    <= bin2gray(wr_ptr_reg); // RULE12
         rd_gray_reg    <= bin2gray(rd_ptr_reg); // RULE12
         wr_sync_reg[0] <= wr_gray_reg; // RULE8
         rd_sync_reg[0] <= rd_gray_reg; // RULE8
         for (int i = 1; i < fifo_sync_pkg::SYNC_STAGES; i++)
         begin
            wr_sync_reg[i] <= wr_sync_reg[i-1];
            rd_sync_reg[i] <= rd_sync_reg[i-1];
         end
         wr_bin_pipe_reg <= gray2bin(wr_sync_reg[fifo_sync_pkg::SYNC_STAGES-1]); // RULE2
         rd_bin_pipe_reg <= gray2bin(rd_sync_reg[fifo_sync_pkg::SYNC_STAGES-1]); // RULE1
      end
   end
   // read sequencing; wide reads take two entries over two cycles so the
   // gray pointer still moves by one step per cycle
   always_comb
   begin
      pop        = 1'b0;
      state_next = state_reg;
      case (state_reg)
         fifo_sync_pkg::RD_IDLE:
         begin
            if (wide_read_i)
            begin
               if (rd_en_i && (rd_count_reg >= fifo_sync_pkg::TWO_WORDS)) // RULE9
               begin
                  pop        = 1'b1;
                  state_next = fifo_sync_pkg::RD_SECOND;
               end
            end
            else if (fwft_mode_i)
               pop = !core_empty_reg && (!valid_reg || rd_en_i); // RULE9
            else
               pop = rd_en_i && !core_empty_reg;
         end
         fifo_sync_pkg::RD_SECOND:
         begin
            pop        = 1'b1;
            state_next = fifo_sync_pkg::RD_IDLE;
         end
         default:
            state_next = fifo_sync_pkg::RD_IDLE;
      endcase
   end
   assign rd_ptr_next = rd_ptr_reg + fifo_sync_pkg::ptr_t'(pop);
   // empty sets at once from the read pointer, clears only once the write news lands
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         rd_ptr_reg     <= fifo_sync_pkg::PTR_RST;
         core_empty_reg <= fifo_sync_pkg::EMPTY_RST;
         rd_count_reg   <= fifo_sync_pkg::PTR_RST;
         state_reg      <= fifo_sync_pkg::RD_IDLE;
      end
      else
      begin
         rd_ptr_reg     <= rd_ptr_next;
         core_empty_reg <= (wr_bin_pipe_reg == rd_ptr_next); // RULE11 RULE2
         rd_count_reg   <= wr_bin_pipe_reg - rd_ptr_next; // RULE5 RULE6
         state_reg      <= state_next;
      end
   end
   // valid means a one-cycle data strobe, except in fall-through where it means held data
   always_comb
   begin
      if (state_reg == fifo_sync_pkg::RD_SECOND)
         valid_next = 1'b1;
      else if (wide_read_i)
         valid_next = 1'b0;
      else if (fwft_mode_i)
         valid_next = pop ? 1'b1 : (rd_en_i ? 1'b0 : valid_reg);
      else
         valid_next = pop;
   end
   // read data register; low word first in wide mode
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         rd_data_reg <= fifo_sync_pkg::RD_DATA_RST;
         valid_reg   <= 1'b0;
      end
      else
      begin
         valid_reg <= valid_next;
         if (pop && (state_reg == fifo_sync_pkg::RD_SECOND))
            rd_data_reg[fifo_sync_pkg::RD_W-1:fifo_sync_pkg::DATA_W] <= head; // RULE9
         else if (pop)
            rd_data_reg <= {fifo_sync_pkg::ZERO_WORD, head};
      end
   end
   // a depth of 16 against a 6-cycle clear delay keeps full and empty apart here
   assign full_o     = full_reg; // RULE4 RULE3
   assign wr_count_o = wr_count_reg;
   assign rd_count_o = rd_count_reg;
   assign rd_data_o  = rd_data_reg;
   assign rd_valid_o = valid_reg;
   assign empty_o    = wide_read_i ? (rd_count_reg < fifo_sync_pkg::TWO_WORDS) :
                       (fwft_mode_i ? !valid_reg : core_empty_reg);
   // helper for checks: true occupancy and cycles without pointer movement
   fifo_sync_pkg::ptr_t occ;
   logic [3:0]          idle_cnt_reg;
   assign occ = wr_ptr_reg - rd_ptr_reg;
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         idle_cnt_reg <= 4'h0;
      else if (push || pop)
         idle_cnt_reg <= 4'h0;
      else if (idle_cnt_reg != fifo_sync_pkg::SETTLE_CYCLES)
         idle_cnt_reg <= idle_cnt_reg + 4'h1;
   end

   property p_full_clear_delay;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      pop && full_reg && (occ == fifo_sync_pkg::FULL_LEVEL) |=> full_reg [*5] ##1 !full_reg;
   endproperty
   a_full_clear_delay: assert property (p_full_clear_delay) else $error("full cleared off time"); // RULE1
   property p_empty_clear_delay;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      push && (occ == fifo_sync_pkg::PTR_RST) |=> core_empty_reg [*5] ##1 !core_empty_reg;
   endproperty
   a_empty_clear_delay: assert property (p_empty_clear_delay) else $error("empty cleared off time"); // RULE2
   property p_wr_count_pessimistic;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      wr_count_reg >= occ;
   endproperty
   a_wr_count_pessimistic: assert property (p_wr_count_pessimistic) else $error("write count low"); // RULE6
   property p_rd_count_pessimistic;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      rd_count_reg <= occ;
   endproperty
   a_rd_count_pessimistic: assert property (p_rd_count_pessimistic) else $error("read count high"); // RULE6
   property p_counts_settle;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      idle_cnt_reg == fifo_sync_pkg::SETTLE_CYCLES |-> wr_count_o == occ && rd_count_o == occ;
   endproperty
   a_counts_settle: assert property (p_counts_settle) else $error("counts not settled"); // RULE7
   property p_full_sets;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      push && (occ == 5'h0F) |=> full_o;
   endproperty
   a_full_sets: assert property (p_full_sets) else $error("full late"); // RULE10
   // judged on true occupancy: the read count may lag a write that is still crossing
   property p_empty_sets;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      pop && (occ == fifo_sync_pkg::ONE_WORD) |=> core_empty_reg;
   endproperty
   a_empty_sets: assert property (p_empty_sets) else $error("empty late"); // RULE11
   property p_gray_one_bit;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      $onehot0(wr_gray_reg ^ $past(wr_gray_reg)) && $onehot0(rd_gray_reg ^ $past(rd_gray_reg));
   endproperty
   a_gray_one_bit: assert property (p_gray_one_bit) else $error("gray step too wide"); // RULE12
   property p_wide_read;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      state_reg == fifo_sync_pkg::RD_IDLE && wide_read_i && pop |=> pop ##1 rd_valid_o;
   endproperty
   a_wide_read: assert property (p_wide_read) else $error("wide read sequence broken"); // RULE9
   c_full: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) $rose(full_o));
   c_drain: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
      full_o ##[1:60] core_empty_reg);
   c_wide: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
      wide_read_i && rd_valid_o);
   c_fwft: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
      fwft_mode_i && rd_valid_o && rd_en_i ##1 rd_valid_o);
endmodule // dual_clock_fifo_status_sync
`default_nettype wire

// ### hdl/fifo_sync_pkg.sv
// shared constants and types for the cross-domain fifo status logic
package fifo_sync_pkg;
   localparam int DATA_W        = 8;   // write word width
   localparam int RD_W          = 16;  // read port width (wide mode uses all of it)
   localparam int ADDR_W        = 4;
   localparam int PTR_W         = 5;   // one wrap bit above the address
   localparam int DEPTH         = 16;
   localparam int SYNC_STAGES   = 2;   // synchronizer stages per pointer crossing
   localparam int BUF_DEPTH     = 4;   // words in the write staging buffer
   localparam int CLK_PERIOD_NS = 20;
   // flag clear delay in periods: one on the acting side plus three plus the chain
   localparam int FLAG_CLEAR_CYCLES = 1 + 3 + SYNC_STAGES;

   localparam logic [PTR_W-1:0]  FULL_LEVEL    = 5'h10;
   localparam logic [PTR_W-1:0]  TWO_WORDS     = 5'h02;
   localparam logic [PTR_W-1:0]  ONE_WORD      = 5'h01;
   localparam logic [PTR_W-1:0]  PTR_RST       = 5'h00;
   localparam logic              FULL_RST      = 1'b0;
   localparam logic              EMPTY_RST     = 1'b1;
   localparam logic [DATA_W-1:0] ZERO_WORD     = 8'h00;
   localparam logic [RD_W-1:0]   RD_DATA_RST   = 16'h0000;
   localparam logic [3:0]        SETTLE_CYCLES = 4'h8;

   typedef logic [PTR_W-1:0] ptr_t;

   typedef enum logic [0:0] {RD_IDLE, RD_SECOND} read_state_t;
endpackage

// ### hdl/stream_fifo.sv
// small valid/ready fifo held in flip-flops, used as write staging buffer
`timescale 1ns/1ns
`default_nettype none
module stream_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   input  wire logic             core_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [IDX_W-1:0] wr_idx_reg;
   logic [IDX_W-1:0] rd_idx_reg;
   logic [CNT_W-1:0] count_reg;
   logic             push;
   logic             pop;

   // honest flags straight from the count
   assign in_ready_o  = (count_reg != FULL_CNT);
   assign out_valid_o = (count_reg != '0);
   assign out_data_o  = mem_reg[rd_idx_reg];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // storage has no reset; only entries behind a valid count are ever read
   always_ff @(posedge core_clk_i)
   begin
      if (push)
         mem_reg[wr_idx_reg] <= in_data_i;
   end

   // index and occupancy bookkeeping
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         wr_idx_reg <= '0;
         rd_idx_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
            wr_idx_reg <= (wr_idx_reg == LAST_IDX) ? '0 : wr_idx_reg + 1'b1;
         if (pop)
            rd_idx_reg <= (rd_idx_reg == LAST_IDX) ? '0 : rd_idx_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end

   // a stalled head word must neither vanish nor change
   property p_head_holds;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
   endproperty
   a_head_holds: assert property (p_head_holds) else $error("staging head lost under stall");

   property p_fills_when_stalled;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (!out_ready_i && in_valid_i) [*4] |-> !in_ready_o || ($past(count_reg) < count_reg);
   endproperty
   a_fills_when_stalled: assert property (p_fills_when_stalled) else $error("buffer not filling");
endmodule // stream_fifo
`default_nettype wire

// ### sim/fifo_peer_model.sv
// writer and reader peers that feed and drain the fifo under test
`timescale 1ns/1ns
`default_nettype none
module fifo_peer_model
(
   input  wire logic                           core_clk_i,
   input  wire logic                           fwft_i,
   input  wire logic                           wr_ready_i,
   input  wire logic                           empty_i,
   input  wire logic                           rd_valid_i,
   input  wire logic [fifo_sync_pkg::RD_W-1:0] rd_data_i,
   output logic                                wr_valid_o,
   output logic [fifo_sync_pkg::DATA_W-1:0]    wr_data_o,
   output logic                                rd_en_o
);
   logic [fifo_sync_pkg::RD_W-1:0] got_q[$];

   initial
   begin
      wr_valid_o = 1'b0;
      wr_data_o = 8'h00;
      rd_en_o = 1'b0;
   end

   // fwft holds its word until taken, the other modes pulse valid once
   always @(posedge core_clk_i)
   begin
      if (rd_valid_i && (!fwft_i || rd_en_o))
      begin
         got_q.push_back(rd_data_i);
      end
   end

   // gaps stay far inside 16 words against a 6-cycle flag delay
   task automatic send_words(input int n, input logic [7:0] base, input int gap);
      int g;
      @(posedge core_clk_i);
      for (int i = 0; i < n; i++)
      begin
         wr_valid_o <= 1'b1;
         wr_data_o <= 8'(base + i);
         g = 0;
         do
         begin
            @(posedge core_clk_i);
            g++;
         end
         while (!wr_ready_i && g < 400);
         if (gap > 0 || i == n - 1)
         begin
            // released data shows the inverse so a stale word never looks valid
            wr_valid_o <= 1'b0;
            wr_data_o <= ~wr_data_o;
            repeat (gap) @(posedge core_clk_i);
         end
      end
   endtask

   // a wide take needs a gap of at least 1 since the second pop of a pair is internal
   task automatic read_words(input int n, input int gap);
      int taken;
      int g;
      taken = 0;
      g = 0;
      @(posedge core_clk_i);
      rd_en_o <= 1'b1;
      while (taken < n && g < 400)
      begin
         @(posedge core_clk_i);
         g++;
         if (!empty_i)
         begin
            taken++;
            // the last take is released once, after the loop
            if (taken < n && gap > 0)
            begin
               rd_en_o <= 1'b0;
               repeat (gap) @(posedge core_clk_i);
               rd_en_o <= 1'b1;
            end
         end
      end
      rd_en_o <= 1'b0;
   endtask
endmodule // fifo_peer_model
`default_nettype wire

// ### sim/tb_dual_clock_fifo_status_sync.sv
// self-checking bench for the fifo status and count logic
`timescale 1ns/1ns
`default_nettype none
module tb_dual_clock_fifo_status_sync;
   logic                             core_clk_i = 1'b0;
   logic                             rst_b_i = 1'b0;
   logic                             fwft_mode_i = 1'b0;
   logic                             wide_read_i = 1'b0;
   logic                             wr_valid, wr_ready, full, rd_en, rd_valid, empty;
   logic [fifo_sync_pkg::DATA_W-1:0] wr_data;
   logic [fifo_sync_pkg::RD_W-1:0]   rd_data;
   logic [fifo_sync_pkg::PTR_W-1:0]  wr_count, rd_count;
   int                               err_total = 0;
   int                               check_count = 0;
   int                               k;

   always #(fifo_sync_pkg::CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;

   dual_clock_fifo_status_sync i_dut
   (
      .core_clk_i  (core_clk_i),
      .rst_b_i     (rst_b_i),
      .wr_valid_i  (wr_valid),
      .wr_data_i   (wr_data),
      .wr_ready_o  (wr_ready),
      .full_o      (full),
      .wr_count_o  (wr_count),
      .rd_en_i     (rd_en),
      .fwft_mode_i (fwft_mode_i),
      .wide_read_i (wide_read_i),
      .rd_data_o   (rd_data),
      .rd_valid_o  (rd_valid),
      .empty_o     (empty),
      .rd_count_o  (rd_count)
   );

   fifo_peer_model i_peer
   (
      .core_clk_i (core_clk_i),
      .fwft_i     (fwft_mode_i),
      .wr_ready_i (wr_ready),
      .empty_i    (empty),
      .rd_valid_i (rd_valid),
      .rd_data_i  (rd_data),
      .wr_valid_o (wr_valid),
      .wr_data_o  (wr_data),
      .rd_en_o    (rd_en)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic settle();
      repeat (fifo_sync_pkg::SETTLE_CYCLES) @(posedge core_clk_i);
      #1;
   endtask

   // compares captured narrow words against an incrementing run, then clears
   task automatic check_q(input logic [7:0] base, input int n);
      check(32'(i_peer.got_q.size()), 32'(n));
      for (int i = 0; i < n && i < i_peer.got_q.size(); i++)
         check(32'(i_peer.got_q[i]), 32'(8'(base + i)));
      i_peer.got_q.delete();
   endtask

   // edges from the taking edge until the chosen flag reads low
   task automatic flag_delay(input bit use_full, output int n);
      do @(posedge core_clk_i);
      while (!(use_full ? (rd_en && !empty) : (wr_valid && wr_ready)));
      n = 0;
      do
      begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      while ((use_full ? full : empty) === 1'b1 && n < 40);
   endtask

   // both flags together would mean a flag delay outran a fill or drain
   always @(posedge core_clk_i)
   begin
      if (rst_b_i && full === 1'b1 && empty === 1'b1)
      begin
         err_total++;
         $display("ERROR t=%0t full=%h empty=%h", $time, full, empty);
      end
   end

   task automatic test_reset();
      #1;
      check(32'(full), 32'(fifo_sync_pkg::FULL_RST));
      check(32'(empty), 32'(fifo_sync_pkg::EMPTY_RST));
      check(32'(wr_count), 32'(fifo_sync_pkg::PTR_RST));
      check(32'(rd_count), 32'(fifo_sync_pkg::PTR_RST));
      check(32'(rd_data), 32'(fifo_sync_pkg::RD_DATA_RST));
      check(32'({rd_valid, wr_ready}), 32'h1);
      $display("test reset done");
   endtask

   task automatic test_empty_clear();
      fork
         i_peer.send_words(1, 8'hA5, 0);
         flag_delay(1'b0, k);
      join
      check(32'(k), 32'(1 + 3 + fifo_sync_pkg::SYNC_STAGES));
      settle();
      check(32'(wr_count), 32'(fifo_sync_pkg::ONE_WORD));
      check(32'(rd_count), 32'(fifo_sync_pkg::ONE_WORD));
      i_peer.read_words(1, 0);
      #1;
      check(32'(empty), 32'h1);
      @(posedge core_clk_i);
      #1;
      check_q(8'hA5, 1);
      $display("test empty_clear done");
   endtask

   // fill storage and staging until refused, then time the full release
   task automatic test_full();
      i_peer.send_words(20, 8'h20, 0);
      settle();
      check(32'({full, wr_ready}), 32'h2);
      check(32'(wr_count), 32'(fifo_sync_pkg::FULL_LEVEL));
      check(32'(rd_count), 32'(fifo_sync_pkg::FULL_LEVEL));
      fork
         i_peer.read_words(1, 0);
         flag_delay(1'b1, k);
      join
      check(32'(k), 32'(3 + fifo_sync_pkg::SYNC_STAGES));
      @(posedge core_clk_i);
      #1;
      check(32'(full), 32'h1);
      i_peer.read_words(19, 0);
      settle();
      check_q(8'h20, 20);
      check(32'({full, empty}), 32'h1);
      check(32'({wr_count, rd_count}), 32'h0);
      $display("test full done");
   endtask

   // both peers stall; counts must agree once traffic stops
   task automatic test_counts();
      fork
         i_peer.send_words(7, 8'h40, 1);
         i_peer.read_words(3, 3);
      join
      settle();
      check(32'(wr_count), 32'h4);
      check(32'(rd_count), 32'h4);
      i_peer.read_words(4, 0);
      settle();
      check_q(8'h40, 7);
      check(32'({wr_count, rd_count}), 32'h0);
      $display("test counts done");
   endtask

   task automatic test_fwft();
      @(posedge core_clk_i);
      fwft_mode_i <= 1'b1;
      i_peer.send_words(3, 8'h60, 0);
      settle();
      check(32'({rd_valid, empty}), 32'h2);
      check(32'(rd_data), 32'h60);
      check(32'(rd_count), 32'(fifo_sync_pkg::TWO_WORDS));
      i_peer.read_words(3, 0);
      settle();
      check_q(8'h60, 3);
      check(32'(empty), 32'h1);
      @(posedge core_clk_i);
      fwft_mode_i <= 1'b0;
      $display("test fwft done");
   endtask

   // wide pairs put the first written word in the low byte
   task automatic test_wide();
      @(posedge core_clk_i);
      wide_read_i <= 1'b1;
      i_peer.send_words(5, 8'h70, 0);
      settle();
      i_peer.read_words(2, 2);
      settle();
      check(32'(i_peer.got_q.size()), 32'h2);
      check(32'(i_peer.got_q[0]), 32'h7170);
      check(32'(i_peer.got_q[1]), 32'h7372);
      i_peer.got_q.delete();
      check(32'(empty), 32'h1);
      @(posedge core_clk_i);
      wide_read_i <= 1'b0;
      i_peer.read_words(1, 0);
      settle();
      check_q(8'h74, 1);
      $display("test wide done");
   endtask

   initial
   begin
      repeat (5000) @(posedge core_clk_i);
      err_total++;
      stop_test();
   end

   initial
   begin
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      test_reset();
      test_empty_clear();
      test_full();
      test_counts();
      test_fwft();
      test_wide();
      stop_test();
   end
endmodule // tb_dual_clock_fifo_status_sync
`default_nettype wire
